// ==== core/sbcw_pkg.sv ====
// Package: register map, field layout, modes and timing constants of the supervisory block
package sbcw_pkg;

	// Register offsets
	localparam logic [6:0] SBCW_ADR_DEV_MODE   = 7'h01;  // Device mode control
	localparam logic [6:0] SBCW_ADR_SYS_EVT    = 7'h61;  // System event status
	localparam logic [6:0] SBCW_ADR_TRX_EVT    = 7'h63;  // Transceiver event status
	localparam logic [6:0] SBCW_ADR_WAKE_EVT   = 7'h64;  // Wake pin event status
	localparam logic [6:0] SBCW_ADR_SUMMARY    = 7'h60;  // Event summary status
	localparam logic [6:0] SBCW_ADR_SYS_EN     = 7'h04;  // System capture enable
	localparam logic [6:0] SBCW_ADR_TRX_EN     = 7'h23;  // Transceiver capture enable
	localparam logic [6:0] SBCW_ADR_WAKE_EN    = 7'h4C;  // Wake capture enable
	localparam logic [6:0] SBCW_ADR_TRX_MODE   = 7'h20;  // CAN/LIN mode fields
	localparam logic [6:0] SBCW_ADR_PROTECT    = 7'h0A;  // Write protection areas
	localparam logic [6:0] SBCW_ADR_WD_CFG1    = 7'h36;  // Watchdog config one
	localparam logic [6:0] SBCW_ADR_WD_CFG2    = 7'h37;  // Watchdog config two
	localparam logic [6:0] SBCW_ADR_WD_STAT    = 7'h38;  // Watchdog status
	localparam logic [6:0] SBCW_ADR_WD_TRIG    = 7'h39;  // Watchdog trigger
	localparam logic [6:0] SBCW_ADR_IDENTITY   = 7'h7E;  // Device identity

	// Protected address areas, bits 0..6
	localparam logic [6:0] SBCW_AREA_LO [7] = '{7'h06, 7'h10, 7'h20, 7'h30, 7'h40, 7'h50, 7'h67};
	localparam logic [6:0] SBCW_AREA_HI [7] = '{7'h09, 7'h1F, 7'h2F, 7'h3F, 7'h4F, 7'h5F, 7'h6F};
	localparam logic [7:0] SBCW_PROTECT_MASK = 8'h7F;  // Bit 7 reserved

	// Reset values
	localparam logic [7:0] SBCW_RST_PROTECT = 8'h00;
	localparam logic [7:0] SBCW_RST_WD_CFG1 = 8'h42;  // Time-out mode, long window
	localparam logic [7:0] SBCW_RST_WD_CFG2 = 8'h41;  // 128 ms period, default reset length
	localparam logic [7:0] SBCW_RST_EN      = 8'h00;

	// Watchdog mode codes, field bits 7:5
	localparam logic [2:0] SBCW_WD_OFF     = 3'h1;
	localparam logic [2:0] SBCW_WD_TIMEOUT = 3'h2;
	localparam logic [2:0] SBCW_WD_WINDOW  = 3'h4;
	localparam logic [7:0] SBCW_TRIG_PATTERN = 8'h55;

	// Device mode codes
	localparam logic [2:0] SBCW_DM_SLEEP   = 3'h1;
	localparam logic [2:0] SBCW_DM_STANDBY = 3'h4;
	localparam logic [2:0] SBCW_DM_NORMAL  = 3'h7;

	// Fixed event positions in the system register (always captured)
	localparam int SBCW_SYS_PWRON = 0;
	localparam int SBCW_SYS_PNERR = 1;
	localparam int SBCW_SYS_OVT   = 2;
	localparam logic [7:0] SBCW_SYS_ALWAYS = 8'h07;  // power-on, PN overflow, overtemp

	// Timing
	localparam int SBCW_CLK_MHZ      = 250;
	localparam int SBCW_EVT_DELAY_US = 10;  // Event delay timer, microseconds
	localparam int SBCW_EVT_DELAY_CYC = SBCW_EVT_DELAY_US * SBCW_CLK_MHZ;
	localparam int SBCW_WD_PERIOD_CYC = 32000000;  // 128 ms at 250 MHz
	localparam int SBCW_RST_LEN_CYC   = 1000000;   // 4 ms reset pulse

	// Register request carrier, write or read
	typedef struct packed {
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
		logic [6:0] addr;  // Register address
		logic [7:0] data;  // Write data
	} sbcw_req_t;

	// Watchdog state enumeration, one-hot
	typedef enum logic [2:0] {
		SBCW_WS_RUN  = 3'b001,
		SBCW_WS_RST  = 3'b010,
		SBCW_WS_IDLE = 3'b100
	} sbcw_wd_st_t;

endpackage

// ==== core/sbcw_event_bank.sv ====
// Event bank: one group of clear-on-write-one capture bits
`timescale 1ns/100ps
module sbcw_event_bank
	import sbcw_pkg::*;
#(
	parameter int                W       = 8,      // Bits in the group
	parameter logic [W-1:0]      ALWAYS  = '0      // Bits captured regardless of enable
) (
	input  wire logic         clk_i,    // System clock
	input  wire logic         rst_b_i,  // Sync reset, active low
	input  wire logic [W-1:0] evt_i,    // Event pulses, synchronous
	input  wire logic [W-1:0] en_i,     // Capture enables
	input  wire logic [W-1:0] clr_i,    // Write-one clear mask
	input  wire logic         clr_v_i,  // Clear strobe
	output logic      [W-1:0] stat_o,   // Captured status
	output logic              clr_o     // A set bit was cleared
);
	typedef struct packed {
		logic [W-1:0] stat;  // Status bits
		logic         clr;   // Clear pulse
	} sbcw_bank_st_t;

	sbcw_bank_st_t st_q, st_d;

	// Set wins over a simultaneous clear
	always_comb begin
		logic [W-1:0] setm;
		logic [W-1:0] clrm;
		setm = evt_i & (en_i | ALWAYS);
		clrm = clr_v_i ? clr_i : '0;
		st_d.stat = (st_q.stat & ~clrm) | setm;
		st_d.clr  = |(clrm & st_q.stat);
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign stat_o = st_q.stat;
	assign clr_o  = st_q.clr;

	a_bank_set_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(evt_i[0] && (en_i[0] || ALWAYS[0])) |=> stat_o[0]) else $error("event lost");
	a_bank_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(clr_v_i && clr_i[0] && !evt_i[0]) |=> !stat_o[0]) else $error("clear failed");

endmodule // sbcw_event_bank

// ==== core/sbcw_ctrl.sv ====
// Top: event capture, pin signalling, sleep guard, write protection and watchdog
//
// Operation
// - Power-on, PN overflow, overtemp, system always captured
// - Other events captured only when enabled
// - Pending event pulls idle receive pin low
// - Enabled event in Sleep leaves Sleep
// - Normal mode pins carry bus streams when CAN mode bit 0 is set, LIN mode field is 2
// - Write one clears status, zero keeps
// - Summary register shows groups holding events
// - Clear releases pin, starts delay timer
// - Timer expiry re-asserts pin if pending
// - Capture registers readable without side effects
// - Sleep refused without wake source or clean status
// - Read-only identity byte at 0x7E
// - Protection blocks only bus writes
// - Protect bits 0-2 guard low areas
// - Protect bits 3-6 guard upper areas
// - Watchdog on at reset; fault asserts reset, limp
// - Config write outside Standby resets, flags
// - Accepted config write restarts watchdog
// - Window mode only in Normal mode
// - Early trigger in window mode resets
// - Trigger pattern restarts watchdog
`timescale 1ns/100ps
module sbcw_ctrl
	import sbcw_pkg::*;
#(
	parameter int          WD_PERIOD = SBCW_WD_PERIOD_CYC,  // Watchdog period, cycles
	parameter int          RST_LEN   = SBCW_RST_LEN_CYC,    // Reset pulse, cycles
	parameter logic [3:0]  VARIANT   = 4'h0,                // Product variant code
	parameter logic [3:0]  FAMILY    = 4'h5                 // Family code, arbitrary value
) (
	input  wire logic       clk_i,        // 250 MHz clock
	input  wire logic       rst_b_i,      // Sync reset, active low
	input  wire sbcw_req_t  req_i,        // Register request from SPI front end
	output logic [7:0]      rdata_o,      // Read data, one cycle after rd
	input  wire logic [7:0] sys_evt_i,    // System event pulses
	input  wire logic [7:0] trx_evt_i,    // Transceiver event pulses
	input  wire logic [7:0] wake_evt_i,   // Wake pin event pulses
	input  wire logic       io_ok_i,      // I/O supply present (pin)
	input  wire logic       can_rx_i,     // CAN bit stream
	input  wire logic       lin_rx_i,     // LIN bit stream
	output logic            can_rxd_o,    // CAN receive pin
	output logic            lin_rxd_o,    // LIN receive pin
	output logic [2:0]      dev_mode_o,   // Current device mode
	output logic            mcu_reset_out_b_o, // Microcontroller reset, active low
	output logic            limp_home_out_o    // Limp-home output
);
	////////////////////////////////////////////////////////////////////////////
	// State
	localparam logic [31:0] DLY = 32'(SBCW_EVT_DELAY_CYC);

	typedef struct packed {
		logic [2:0]  mode;      // Device mode field
		logic [1:0]  can_mode;  // CAN mode field
		logic [1:0]  lin_mode;  // LIN mode field
		logic [7:0]  sys_en;    // Capture enables
		logic [7:0]  trx_en;
		logic [7:0]  wake_en;
		logic [7:0]  protect;   // Write protection areas
		logic [7:0]  wd_cfg1;   // Watchdog config one
		logic [7:0]  wd_cfg2;   // Watchdog config two
		logic [2:0]  wd_flags;  // Illegal config, overflow, early
		sbcw_wd_st_t wd_st;     // Watchdog state
		logic [31:0] wd_cnt;    // Watchdog timer
		logic [31:0] dly_cnt;   // Event delay timer
		logic        hold;      // Pin held high during delay
		logic [7:0]  rdata;     // Read data
		logic        can_rxd;
		logic        lin_rxd;
		logic        io_s1;     // Supply synchroniser
		logic        io_s2;
		logic        can_s1;    // Stream synchronisers
		logic        can_s2;
		logic        lin_s1;
		logic        lin_s2;
		logic        rst_out_b; // MCU reset output, active low
		logic        limp;      // Limp-home output
	} sbcw_st_t;

	sbcw_st_t st_q, st_d;

	logic [7:0] sys_stat, trx_stat, wake_stat;  // Captured status
	logic       sys_clr, trx_clr, wake_clr;     // Bits actually cleared
	logic       wr_ok;                          // Write passes protection
	logic       clr_sys_v, clr_trx_v, clr_wake_v;

	////////////////////////////////////////////////////////////////////////////
	// Protection lookup
	function automatic logic locked(input logic [6:0] a, input logic [7:0] p);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (p[i] && a >= SBCW_AREA_LO[i] && a <= SBCW_AREA_HI[i]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic valid_mode(input logic [2:0] m);
		return m == SBCW_WD_OFF || m == SBCW_WD_TIMEOUT || m == SBCW_WD_WINDOW;
	endfunction

	// Only bus writes are checked; status capture below ignores protection
	assign wr_ok      = req_i.wr && !locked(req_i.addr, st_q.protect);
	assign clr_sys_v  = wr_ok && req_i.addr == SBCW_ADR_SYS_EVT;
	assign clr_trx_v  = wr_ok && req_i.addr == SBCW_ADR_TRX_EVT;
	assign clr_wake_v = wr_ok && req_i.addr == SBCW_ADR_WAKE_EVT;

	////////////////////////////////////////////////////////////////////////////
	// Event groups
	sbcw_event_bank #(.W(8), .ALWAYS(SBCW_SYS_ALWAYS)) u_sys (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.evt_i   (sys_evt_i),
		.en_i    (st_q.sys_en),
		.clr_i   (req_i.data),
		.clr_v_i (clr_sys_v),
		.stat_o  (sys_stat),
		.clr_o   (sys_clr)
	);
	sbcw_event_bank #(.W(8)) u_trx (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.evt_i   (trx_evt_i),
		.en_i    (st_q.trx_en),
		.clr_i   (req_i.data),
		.clr_v_i (clr_trx_v),
		.stat_o  (trx_stat),
		.clr_o   (trx_clr)
	);
	sbcw_event_bank #(.W(8)) u_wake (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.evt_i   (wake_evt_i),
		.en_i    (st_q.wake_en),
		.clr_i   (req_i.data),
		.clr_v_i (clr_wake_v),
		.stat_o  (wake_stat),
		.clr_o   (wake_clr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic pending;
		logic wake_src;
		logic wd_cfg_wr;
		logic trig;
		logic win;
		logic fault;
		logic [7:0] sum;
		st_d = st_q;
		pending  = |{sys_stat, trx_stat, wake_stat};
		wake_src = |st_q.wake_en || st_q.trx_en[0];  // Regular wake sources
		sum      = {5'h00, |wake_stat, |trx_stat, |sys_stat};
		wd_cfg_wr = req_i.wr && (req_i.addr == SBCW_ADR_WD_CFG1
			|| req_i.addr == SBCW_ADR_WD_CFG2) && !locked(req_i.addr, st_q.protect);
		trig  = wr_ok && req_i.addr == SBCW_ADR_WD_TRIG && req_i.data == SBCW_TRIG_PATTERN;
		// Window mode only while Normal; time-out otherwise
		win   = st_q.wd_cfg1[7:5] == SBCW_WD_WINDOW && st_q.mode == SBCW_DM_NORMAL;
		fault = 1'b0;

		// Synchronisers
		st_d.io_s1  = io_ok_i;
		st_d.io_s2  = st_q.io_s1;
		st_d.can_s1 = can_rx_i;
		st_d.can_s2 = st_q.can_s1;
		st_d.lin_s1 = lin_rx_i;
		st_d.lin_s2 = st_q.lin_s1;

		// Register writes
		if (wr_ok) begin
			unique case (req_i.addr)
				SBCW_ADR_DEV_MODE: begin
					if (req_i.data[2:0] == SBCW_DM_SLEEP && (!wake_src || pending)) begin
						st_d.mode = SBCW_DM_STANDBY;
					end else begin
						st_d.mode = req_i.data[2:0];
					end
				end
				SBCW_ADR_SYS_EN:  st_d.sys_en  = req_i.data;
				SBCW_ADR_TRX_EN:  st_d.trx_en  = req_i.data;
				SBCW_ADR_WAKE_EN: st_d.wake_en = req_i.data;
				SBCW_ADR_TRX_MODE: begin
					st_d.can_mode = req_i.data[1:0];
					st_d.lin_mode = req_i.data[3:2];
				end
				SBCW_ADR_PROTECT: st_d.protect = req_i.data & SBCW_PROTECT_MASK;
				SBCW_ADR_WD_STAT: st_d.wd_flags = st_q.wd_flags & ~req_i.data[2:0];
				default: ;
			endcase
		end

		// Watchdog configuration
		if (wd_cfg_wr) begin
			if (st_q.mode != SBCW_DM_STANDBY) begin
				st_d.wd_flags[2] = 1'b1;
				fault = 1'b1;
			end else begin
				if (req_i.addr == SBCW_ADR_WD_CFG1) begin
					if (valid_mode(req_i.data[7:5])) st_d.wd_cfg1 = req_i.data;
				end else begin
					st_d.wd_cfg2 = req_i.data;
				end
				st_d.wd_cnt = '0;
			end
		end

		// Watchdog timer
		unique case (st_q.wd_st)
			SBCW_WS_RUN: begin
				if (st_q.wd_cfg1[7:5] == SBCW_WD_OFF) begin
					st_d.wd_cnt = '0;
				end else if (trig) begin
					if (win && st_q.wd_cnt < 32'(WD_PERIOD / 2)) begin
						st_d.wd_flags[0] = 1'b1;
						fault = 1'b1;
					end else begin
						st_d.wd_cnt = '0;
					end
				end else if (!wd_cfg_wr) begin
					if (st_q.wd_cnt >= 32'(WD_PERIOD - 1)) begin
						st_d.wd_flags[1] = 1'b1;
						fault = 1'b1;
					end else begin
						st_d.wd_cnt = st_q.wd_cnt + 32'h1;
					end
				end
				if (fault) begin
					st_d.wd_st  = SBCW_WS_RST;
					st_d.wd_cnt = '0;
				end
			end
			SBCW_WS_RST: begin
				if (st_q.wd_cnt >= 32'(RST_LEN - 1)) begin
					st_d.wd_st  = SBCW_WS_RUN;
					st_d.wd_cnt = '0;
					st_d.mode   = SBCW_DM_STANDBY;
				end else begin
					st_d.wd_cnt = st_q.wd_cnt + 32'h1;
				end
			end
			SBCW_WS_IDLE: st_d.wd_st = SBCW_WS_RUN;
			default: st_d.wd_st = SBCW_WS_RUN;
		endcase
		// Registered so the reset pins never glitch on a state decode
		st_d.rst_out_b = st_d.wd_st != SBCW_WS_RST;
		st_d.limp      = st_d.wd_st == SBCW_WS_RST;

		// Enabled event wakes from Sleep
		if (st_q.mode == SBCW_DM_SLEEP && pending) begin
			st_d.mode = SBCW_DM_STANDBY;
		end

		// Delay timer after any clear of a set bit
		if (sys_clr || trx_clr || wake_clr) begin
			st_d.hold    = 1'b1;
			st_d.dly_cnt = '0;
		end else if (st_q.hold) begin
			if (st_q.dly_cnt >= DLY - 32'h1) begin
				st_d.hold = 1'b0;
			end else begin
				st_d.dly_cnt = st_q.dly_cnt + 32'h1;
			end
		end

		// Receive pins: stream in active modes, otherwise event flag
		if (st_q.mode == SBCW_DM_NORMAL && st_q.can_mode[0]) begin
			st_d.can_rxd = st_q.can_s2;
		end else begin
			st_d.can_rxd = !(pending && st_q.io_s2 && !st_d.hold);
		end
		if (st_q.mode == SBCW_DM_NORMAL && st_q.lin_mode == 2'b10) begin
			st_d.lin_rxd = st_q.lin_s2;
		end else begin
			st_d.lin_rxd = !(pending && st_q.io_s2 && !st_d.hold);
		end

		// Read mux has no side effects on capture or timer
		st_d.rdata = 8'h00;
		if (req_i.rd) begin
			unique case (req_i.addr)
				SBCW_ADR_DEV_MODE:  st_d.rdata = {5'h00, st_q.mode};
				SBCW_ADR_SYS_EVT:   st_d.rdata = sys_stat;
				SBCW_ADR_TRX_EVT:   st_d.rdata = trx_stat;
				SBCW_ADR_WAKE_EVT:  st_d.rdata = wake_stat;
				SBCW_ADR_SUMMARY:   st_d.rdata = sum;
				SBCW_ADR_SYS_EN:    st_d.rdata = st_q.sys_en;
				SBCW_ADR_TRX_EN:    st_d.rdata = st_q.trx_en;
				SBCW_ADR_WAKE_EN:   st_d.rdata = st_q.wake_en;
				SBCW_ADR_TRX_MODE:  st_d.rdata = {4'h0, st_q.lin_mode, st_q.can_mode};
				SBCW_ADR_PROTECT:   st_d.rdata = st_q.protect;
				SBCW_ADR_WD_CFG1:   st_d.rdata = st_q.wd_cfg1;
				SBCW_ADR_WD_CFG2:   st_d.rdata = st_q.wd_cfg2;
				SBCW_ADR_WD_STAT:   st_d.rdata = {5'h00, st_q.wd_flags};
				SBCW_ADR_IDENTITY:  st_d.rdata = {FAMILY, VARIANT};
				default:            st_d.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_q          <= '0;
			st_q.mode     <= SBCW_DM_STANDBY;
			st_q.sys_en   <= SBCW_RST_EN;
			st_q.protect  <= SBCW_RST_PROTECT;
			st_q.wd_cfg1  <= SBCW_RST_WD_CFG1;  // Watchdog on at power-up
			st_q.wd_cfg2  <= SBCW_RST_WD_CFG2;
			st_q.wd_st    <= SBCW_WS_IDLE;
			st_q.can_rxd  <= 1'b1;
			st_q.lin_rxd  <= 1'b1;
			st_q.rst_out_b <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o           = st_q.rdata;
	assign can_rxd_o         = st_q.can_rxd;
	assign lin_rxd_o         = st_q.lin_rxd;
	assign dev_mode_o        = st_q.mode;
	assign mcu_reset_out_b_o = st_q.rst_out_b;
	assign limp_home_out_o   = st_q.limp;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_sleep_guard: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_ok && req_i.addr == SBCW_ADR_DEV_MODE && req_i.data[2:0] == SBCW_DM_SLEEP
		&& (sys_stat != 0)) |=> dev_mode_o == SBCW_DM_STANDBY) else $error("sleep allowed");
	a_illegal_cfg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(req_i.wr && req_i.addr == SBCW_ADR_WD_CFG1 && !locked(req_i.addr, st_q.protect)
		&& dev_mode_o == SBCW_DM_NORMAL && st_q.wd_st == SBCW_WS_RUN)
		|=> !mcu_reset_out_b_o && st_q.wd_flags[2]) else $error("no reset on bad config");
	a_protect_blk: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(req_i.wr && req_i.addr == SBCW_ADR_TRX_EN && st_q.protect[2])
		|=> $stable(st_q.trx_en)) else $error("lock leak");
	a_ident_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(req_i.rd && req_i.addr == SBCW_ADR_IDENTITY) |=> rdata_o == {FAMILY, VARIANT})
		else $error("bad identity");
	a_pin_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(sys_clr && dev_mode_o == SBCW_DM_STANDBY) |=> can_rxd_o) else $error("pin not released");
	a_reset_limp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.wd_st == SBCW_WS_RUN && st_q.wd_cfg1[7:5] == SBCW_WD_TIMEOUT
		&& st_q.wd_cnt == 32'(WD_PERIOD - 1) && !req_i.wr)
		|=> !mcu_reset_out_b_o && limp_home_out_o) else $error("no reset on overflow");
	a_early_trig: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.wd_st == SBCW_WS_RUN && wr_ok && req_i.addr == SBCW_ADR_WD_TRIG
		&& req_i.data == SBCW_TRIG_PATTERN && dev_mode_o == SBCW_DM_NORMAL
		&& st_q.wd_cfg1[7:5] == SBCW_WD_WINDOW && st_q.wd_cnt < 32'(WD_PERIOD / 2))
		|=> !mcu_reset_out_b_o) else $error("early trigger accepted");
	a_wake_sleep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(dev_mode_o == SBCW_DM_SLEEP && wake_stat != 0 && st_q.wd_st == SBCW_WS_RUN
		&& !wr_ok) |=> dev_mode_o == SBCW_DM_STANDBY) else $error("stuck in sleep");
	c_clear_evt: cover property (@(posedge clk_i) disable iff (!rst_b_i) sys_clr);
	c_wd_reset:  cover property (@(posedge clk_i) disable iff (!rst_b_i) !mcu_reset_out_b_o);
	c_hold_end:  cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(st_q.hold));

endmodule // sbcw_ctrl

// ==== testbench/sbcw_host_model.sv ====
// Host microcontroller model: register requests over the block's request port
`timescale 1ns/100ps
module sbcw_host_model
	import sbcw_pkg::*;
(
	input  wire logic       clk_i,    // System clock
	input  wire logic [7:0] rdata_i,  // Read data from the block
	output sbcw_req_t       req_o     // Register request
);
	// Idle until the bench asks for a transfer
	initial begin
		req_o = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One write, held for exactly one sampled edge
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		req_o = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(posedge clk_i);
		#1;
		req_o = '0;
	endtask
	// One read; data is registered, so it is taken one cycle after the strobe
	task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		req_o = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge clk_i);
		#1;
		req_o = '0;
		d = rdata_i;
	endtask
	// Clear only what was seen set, so late events survive the write
	task automatic clear_seen(input logic [6:0] a);
		logic [7:0] seen;
		rd_reg(a, seen);
		wr_reg(a, seen);
	endtask
	// Service the watchdog with the fixed trigger pattern
	task automatic trig;
		wr_reg(SBCW_ADR_WD_TRIG, SBCW_TRIG_PATTERN);
	endtask
endmodule  // sbcw_host_model

// ==== testbench/sbcw_event_lock_watchdog_ctrl_tb.sv ====
// Testbench: register map, event signalling, sleep guard and watchdog
`timescale 1ns/100ps
module sbcw_event_lock_watchdog_ctrl_tb
	import sbcw_pkg::*;
;
	localparam logic [7:0] ID_EXP = 8'hA3;  // Family A, variant 3, both arbitrary
	logic       clk = 1'b0;        // 250 MHz clock
	logic       rst_b = 1'b0;      // Reset, active low
	sbcw_req_t  req;               // Host request
	logic [7:0] rdata;             // Read data
	logic [7:0] sys_e = 8'h00;     // System event pulses
	logic [7:0] trx_e = 8'h00;     // Transceiver event pulses
	logic [7:0] wk_e = 8'h00;      // Wake event pulses
	logic       io_ok = 1'b1;      // I/O supply present
	logic       can_rx = 1'b1;     // CAN stream
	logic       lin_rx = 1'b1;     // LIN stream
	logic       can_rxd;           // CAN receive pin
	logic       lin_rxd;           // LIN receive pin
	logic [2:0] mode;              // Device mode
	logic       mcu_rst_b;         // MCU reset, active low
	logic       limp;              // Limp-home
	int         fails = 0;         // Mismatches
	int         checks_done = 0;   // Comparisons
	int         cyc = 0;           // Cycle count for the hang guard
	logic [7:0] v;                 // Read-back byte
	// Rows: {write, addr[6:0]}, data, expected read-back
	// Last two: bad watchdog mode code ignored, second config byte taken in Standby
	logic [23:0] rows [12] = '{24'h0A_00_00, 24'h7E_00_A3, 24'hFE_FF_A3, 24'h8A_FF_7F,
		24'hA3_FF_00, 24'hCC_FF_00, 24'h84_08_08, 24'h8A_00_00, 24'hA3_01_01, 24'hCC_01_01,
		24'hB6_02_22, 24'hB7_12_12};
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	// Short periods keep watchdog runs brief
	sbcw_ctrl #(.WD_PERIOD(200), .RST_LEN(20), .VARIANT(4'h3), .FAMILY(4'hA)) DUT (
		.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .rdata_o(rdata), .sys_evt_i(sys_e),
		.trx_evt_i(trx_e), .wake_evt_i(wk_e), .io_ok_i(io_ok), .can_rx_i(can_rx),
		.lin_rx_i(lin_rx), .can_rxd_o(can_rxd), .lin_rxd_o(lin_rxd), .dev_mode_o(mode),
		.mcu_reset_out_b_o(mcu_rst_b), .limp_home_out_o(limp));
	sbcw_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
	////////////////////////////////////////////////////////////////////////////////
	// Compare tasks, one per kind of result
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// Wait whole cycles, landing just after an edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle event pulses on all three groups
	task automatic evt(input logic [7:0] s, input logic [7:0] t, input logic [7:0] w);
		@(posedge clk);
		#1;
		{sys_e, trx_e, wk_e} = {s, t, w};
		wait_cyc(1);
		{sys_e, trx_e, wk_e} = '0;
	endtask
	// Bounded wait for the MCU reset to fall
	task automatic wait_rst;
		for (int i = 0; i < 300 && mcu_rst_b !== 1'b0; i++) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wait_cyc(8);
		rst_b = 1'b1;
		chk_bit(can_rxd, 1'b1);
		chk_bit(mcu_rst_b, 1'b1);
		chk_byte({5'h00, mode}, {5'h00, SBCW_DM_STANDBY});
		host.rd_reg(SBCW_ADR_IDENTITY, v);
		chk_byte(v, ID_EXP);
		// Watchdog off first so the short period cannot bite; configured before use
		host.wr_reg(SBCW_ADR_WD_CFG1, 8'h22);
		host.clear_seen(SBCW_ADR_SYS_EVT);
		host.clear_seen(SBCW_ADR_TRX_EVT);
		host.clear_seen(SBCW_ADR_WAKE_EVT);
		host.clear_seen(SBCW_ADR_WD_STAT);
		// Register table: reset, read-only, reserved bit, protected areas
		foreach (rows[i]) begin
			if (rows[i][23]) host.wr_reg(rows[i][22:16], rows[i][15:8]);
			host.rd_reg(rows[i][22:16], v);
			chk_byte(v, rows[i][7:0]);
		end
		// Fixed, enabled and disabled sources in one go
		evt(8'h19, 8'h03, 8'h02);
		host.rd_reg(SBCW_ADR_SYS_EVT, v);
		chk_byte(v, 8'h09);
		host.rd_reg(SBCW_ADR_TRX_EVT, v);
		chk_byte(v, 8'h01);
		host.rd_reg(SBCW_ADR_SUMMARY, v);
		chk_byte(v, 8'h03);
		wait_cyc(2600);
		chk_bit(can_rxd, 1'b0);
		chk_bit(lin_rxd, 1'b0);
		io_ok = 1'b0;
		wait_cyc(6);
		chk_bit(can_rxd, 1'b1);
		io_ok = 1'b1;
		wait_cyc(6);
		// Partial clear releases the pin and restarts the delay
		host.wr_reg(SBCW_ADR_SYS_EVT, 8'h01);
		wait_cyc(3);
		chk_bit(can_rxd, 1'b1);
		host.rd_reg(SBCW_ADR_SYS_EVT, v);
		chk_byte(v, 8'h08);
		evt(8'h00, 8'h00, 8'h01);
		wait_cyc(2000);
		chk_bit(lin_rxd, 1'b1);
		wait_cyc(600);
		chk_bit(lin_rxd, 1'b0);
		// Sleep refused while events are pending
		host.wr_reg(SBCW_ADR_DEV_MODE, {5'h00, SBCW_DM_SLEEP});
		wait_cyc(2);
		chk_byte({5'h00, mode}, {5'h00, SBCW_DM_STANDBY});
		host.clear_seen(SBCW_ADR_SYS_EVT);
		host.clear_seen(SBCW_ADR_TRX_EVT);
		host.clear_seen(SBCW_ADR_WAKE_EVT);
		wait_cyc(2600);
		chk_bit(can_rxd, 1'b1);
		host.wr_reg(SBCW_ADR_DEV_MODE, {5'h00, SBCW_DM_SLEEP});
		wait_cyc(2);
		chk_byte({5'h00, mode}, {5'h00, SBCW_DM_SLEEP});
		evt(8'h00, 8'h00, 8'h01);
		wait_cyc(3);
		chk_byte({5'h00, mode}, {5'h00, SBCW_DM_STANDBY});
		host.clear_seen(SBCW_ADR_WAKE_EVT);
		// Normal mode passes both bus streams through
		host.wr_reg(SBCW_ADR_TRX_MODE, 8'h09);
		host.wr_reg(SBCW_ADR_DEV_MODE, {5'h00, SBCW_DM_NORMAL});
		{can_rx, lin_rx} = 2'b00;
		wait_cyc(6);
		chk_byte({6'h00, can_rxd, lin_rxd}, 8'h00);
		{can_rx, lin_rx} = 2'b11;
		wait_cyc(6);
		chk_byte({6'h00, can_rxd, lin_rxd}, 8'h03);
		// Other mode fields: pins fall back to the idle event flag
		host.wr_reg(SBCW_ADR_TRX_MODE, 8'h06);
		{can_rx, lin_rx} = 2'b00;
		wait_cyc(6);
		chk_byte({6'h00, can_rxd, lin_rxd}, 8'h03);
		// Config write outside Standby resets the MCU
		host.wr_reg(SBCW_ADR_WD_CFG1, 8'h22);
		wait_rst();
		chk_bit(limp, 1'b1);
		wait_cyc(30);
		chk_bit(mcu_rst_b, 1'b1);
		host.rd_reg(SBCW_ADR_WD_STAT, v);
		chk_byte(v & 8'h04, 8'h04);
		host.clear_seen(SBCW_ADR_WD_STAT);
		// Time-out mode: trigger keeps it quiet, silence then bites
		host.wr_reg(SBCW_ADR_WD_CFG1, 8'h42);
		wait_cyc(150);
		host.trig();
		wait_cyc(150);
		chk_bit(mcu_rst_b, 1'b1);
		wait_rst();
		chk_bit(mcu_rst_b, 1'b0);
		wait_cyc(30);
		// Window code runs as time-out outside Normal; early trigger is fine
		host.wr_reg(SBCW_ADR_WD_CFG1, 8'h82);
		host.trig();
		wait_cyc(5);
		chk_bit(mcu_rst_b, 1'b1);
		host.wr_reg(SBCW_ADR_DEV_MODE, {5'h00, SBCW_DM_NORMAL});
		host.trig();
		wait_cyc(3);
		chk_bit(mcu_rst_b, 1'b0);
		wait_cyc(30);
		host.rd_reg(SBCW_ADR_WD_STAT, v);
		chk_byte(v & 8'h01, 8'h01);
		host.wr_reg(SBCW_ADR_WD_CFG1, 8'h22);
		print_verdict();
	end
endmodule  // sbcw_event_lock_watchdog_ctrl_tb
